// ===== rtl/rpc_pkg.sv
package rpc_pkg;
	localparam logic [7:0] PRODUCTION_TEST_REG_DEFAULT   = 8'h7f;
	localparam logic [7:0] PRODUCTION_TEST_REG_IDLE_TEMP = 8'hbf;
	localparam logic [5:0] SEL_TRISTATE    = 6'h3f;
	localparam int         SY_CS           = 0;
	localparam int         SY_SCLK         = 1;
	localparam int         SY_SI           = 2;
	localparam int         SY_PA           = 3;
	localparam int         SY_LV           = 4;
	localparam int         SY_W            = 5;
	localparam logic [2:0] BYTE_LAST       = 3'h7;
	localparam logic [5:0] STROBE_FIRST    = 6'h30;
	localparam logic [5:0] STROBE_LAST     = 6'h3d;
	localparam logic [5:0] STB_PWD         = 6'h30;
	localparam logic [5:0] STB_TX          = 6'h31;
	localparam logic [5:0] STB_IDLE        = 6'h32;
	localparam logic [5:0] STB_RX          = 6'h33;
	localparam logic [5:0] STB_CRYSTAL_OFF_STATE        = 6'h34;
	localparam logic [5:0] STB_SYNTH_ON_STATE      = 6'h35;
	localparam logic [5:0] STB_CAL         = 6'h36;
	localparam logic [1:0] PIN_PWD         = 2'h0;
	localparam logic [1:0] PIN_TX          = 2'h1;
	localparam logic [1:0] PIN_IDLE        = 2'h2;
	localparam logic [1:0] PIN_RX          = 2'h3;
	localparam logic [8:0] RATE_BASE       = 9'h100;
	localparam int         RATE_ACC_W      = 28;
	localparam int         NUDGE_SH        = 3;
	localparam logic [2:0] BW_ADD          = 3'h4;
	localparam logic [2:0] BW_FIX_SH       = 3'h3;
	localparam int         BW_CNT_W        = 9;
	localparam int         EST_W           = 8;
	localparam logic [6:0] EST_SPAN        = 7'h7f;
	localparam logic [2:0] LIM_SH_MAX      = 3'h3;
	localparam logic [2:0] GAIN_SH_MIN     = 3'h1;
	localparam int         MC2_MOD_LO      = 4;
	localparam int         MC2_MOD_HI      = 6;
	localparam int         MC2_SYNC_HI     = 2;
	localparam logic [2:0] MOD_OOK         = 3'h3;
	localparam logic [2:0] SYNC_NONE       = 3'h0;
	localparam logic [2:0] SYNC_DUP_A      = 3'h3;
	localparam logic [2:0] SYNC_DUP_B      = 3'h7;
	localparam logic [5:0] SYNC_LEN16      = 6'h10;
	localparam logic [5:0] SYNC_LEN32      = 6'h20;
	localparam logic [3:0] CAL_CYCLES      = 4'h8;
	typedef logic [RATE_ACC_W-1:0] rpc_acc_t;
	typedef logic [BW_CNT_W-1:0] rpc_bwc_t;
	typedef enum logic [2:0] {
		ST_SLEEP, ST_CRYSTAL_OFF_STATE, ST_IDLE, ST_MANUAL_CALIBRATION_STATE, ST_SYNTH_ON_STATE, ST_RX, ST_TX
	} rpc_state_t;
	typedef enum logic [2:0] {
		CMD_NONE, CMD_PWD, CMD_CRYSTAL_OFF_STATE, CMD_IDLE, CMD_RX, CMD_TX, CMD_SYNTH_ON_STATE, CMD_CAL
	} rpc_cmd_t;
	typedef struct packed {
		logic out;
		logic oe;
	} rpc_pad_t;
	typedef struct packed {
		logic        pin_control_enable;
		logic        serial_mode;
		logic [7:0]  production_test_reg;
		logic [5:0]  sel_shared;
		logic [5:0]  sel_a;
		logic [5:0]  sel_b;
		logic [7:0]  rate_mantissa;
		logic [3:0]  rate_exponent;
		logic [1:0]  bandwidth_mantissa;
		logic [1:0]  bandwidth_exponent;
		logic [1:0]  offset_track_limit;
		logic        carrier_gate_bit;
		logic [1:0]  presync_gain;
		logic [1:0]  postsync_gain;
		logic [7:0]  modem_config_two;
		logic [15:0] sync_word;
		logic [7:0]  synth_offset_field;
	} rpc_cfg_t;
	typedef struct packed {
		logic [2:0] bitcnt;
		logic [6:0] sh;
		logic       first;
		logic       valid;
		logic [5:0] hold;
	} rpc_link_t;
	typedef struct packed {
		logic [SY_W-1:0]  s1;
		logic [SY_W-1:0]  s2;
		logic [SY_W-1:0]  prev;
		rpc_state_t       state;
		rpc_cmd_t         pend;
		logic [3:0]       cal_cnt;
		rpc_pad_t         shared;
		rpc_pad_t         pad_a;
		rpc_pad_t         pad_b;
		logic             temp_route;
		rpc_acc_t         acc;
		logic             sym_tick;
		logic             rx_prev;
		logic             rec_bit;
		rpc_bwc_t         bw_cnt;
		logic             bw_tick;
		logic [EST_W-1:0] est;
		logic             post_sync;
		logic [7:0]       tune;
		logic [31:0]      tx_sh;
		logic [5:0]       tx_left;
		logic             tx_bit;
		logic [31:0]      rx_sh;
		logic             aligned;
		logic             cs_prev;
		logic [2:0]       rx_bits;
		logic [7:0]       rx_byte;
		logic             byte_valid;
		logic             sync_hit;
	} rpc_core_t;
endpackage

// ===== rtl/rpc_radio_pin_ctrl.sv
// Behaviour
// [RL1] select low: shared pin is serial out
// [RL2] shared pin tristate after reset, else status
// [RL3] serial mode transmit: pin a is input
// [RL4] default test value: sensor only synth on
// [RL5] host writes alternate test value for idle
// [RL6] pin control only when enable set
// [RL7] select fall latches clock/input into strobe
// [RL8] strobe only changes state, never restarts
// [RL9] power-down deferred until select high
// [RL10] select low wakes sleep into idle
// [RL11] rate from mantissa and exponent accumulator
// [RL12] host carries rounded mantissa into exponent
// [RL13] rate step doubles per exponent
// [RL14] filter period 8*(4+m)*2^e clocks
// [RL15] publish offset estimate; write retunes synth
// [RL16] tracking limit fraction of bandwidth
// [RL17] gate bit freezes until carrier sense
// [RL18] separate gains before and after sync
// [RL19] no offset compensation with on-off keying
// [RL20] symbol clock recovered, continuously resynchronised
// [RL21] sync word inserted, searched for alignment
// [RL22] sync detect on: accept matching packets only
// [RL23] pin strobes share spi strobe path
`timescale 1ns/1ps
`default_nettype none
module rpc_radio_pin_ctrl #(
	parameter int STATUS_W = 64
) (
	input  wire logic                 clk,                   // crystal clock
	input  wire logic                 rstn,                  // async reset
	input  wire logic                 spi_sclk,              // link clock
	input  wire logic                 chip_select_low,       // spi select
	input  wire logic                 spi_si,                // spi serial in
	input  wire logic                 spi_so_data,           // framer out bit
	input  wire logic                 status_pin_a_in,       // pin a level
	input  wire rpc_pkg::rpc_cfg_t    cfg,                   // configuration
	input  wire logic [STATUS_W-1:0]  status_vec,            // status sources
	input  wire logic                 rx_data,               // demod bit
	input  wire logic signed [7:0]    freq_err,              // offset error
	input  wire logic                 carrier_sense,         // carrier level
	input  wire logic                 tx_packet_start,       // packet start
	input  wire logic                 packet_done,           // packet end
	input  wire logic                 synth_offset_write,    // offset load
	output var rpc_pkg::rpc_pad_t     shared_status_out_pin, // shared pad
	output var rpc_pkg::rpc_pad_t     status_pin_a,          // pad a
	output var rpc_pkg::rpc_pad_t     status_pin_b,          // pad b
	output var rpc_pkg::rpc_state_t   radio_state,           // radio state
	output var logic                  temp_sensor_route,     // sensor on pin a
	output var logic                  serial_tx_data,        // serial tx in
	output var logic                  mod_tx_bit,            // modulator bit
	output var logic                  tx_sync_busy,          // sync sending
	output var logic                  symbol_tick,           // symbol strobe
	output var logic                  recovered_bit,         // sampled bit
	output var logic                  bw_sample_tick,        // filter strobe
	output var logic [7:0]            offset_estimate,       // estimate
	output var logic [7:0]            synth_tune,            // synth offset
	output var logic                  sync_found,            // sync pulse
	output var logic                  rx_byte_valid,         // byte strobe
	output var logic [7:0]            rx_byte                // aligned byte
);
	rpc_pkg::rpc_link_t  lk;
	rpc_pkg::rpc_link_t  ln;
	rpc_pkg::rpc_core_t  r;
	rpc_pkg::rpc_core_t  n;
	rpc_pkg::rpc_cmd_t   cmd;
	rpc_pkg::rpc_state_t tgt;
	logic                link_rstn;
	logic                cs_hi;
	logic                cs_fall;
	logic                fs_on;
	logic                ook;
	logic                frozen;
	logic                sync_on;
	logic                mode32;
	logic [7:0]          hdr;
	logic [8:0]          rate_sum;
	rpc_pkg::rpc_acc_t   inc;
	logic [28:0]         nco;
	logic [28:0]         nudge;
	logic [2:0]          bw_sum;
	rpc_pkg::rpc_bwc_t   bw_per;
	logic [1:0]          gain;
	logic signed [7:0]   step;
	logic [6:0]          limit;
	logic signed [8:0]   lim_s;
	logic signed [8:0]   acc_e;
	logic [31:0]         rx_new;
	logic                hit;

	function automatic rpc_pkg::rpc_cmd_t pin_cmd(input logic [1:0] code);
		case (code)
			rpc_pkg::PIN_PWD:  pin_cmd = rpc_pkg::CMD_PWD;
			rpc_pkg::PIN_TX:   pin_cmd = rpc_pkg::CMD_TX;
			rpc_pkg::PIN_IDLE: pin_cmd = rpc_pkg::CMD_IDLE;
			default:           pin_cmd = rpc_pkg::CMD_RX;
		endcase
	endfunction

	function automatic rpc_pkg::rpc_cmd_t spi_cmd(input logic [5:0] a);
		case (a)
			rpc_pkg::STB_PWD:    spi_cmd = rpc_pkg::CMD_PWD;
			rpc_pkg::STB_TX:     spi_cmd = rpc_pkg::CMD_TX;
			rpc_pkg::STB_IDLE:   spi_cmd = rpc_pkg::CMD_IDLE;
			rpc_pkg::STB_RX:     spi_cmd = rpc_pkg::CMD_RX;
			rpc_pkg::STB_CRYSTAL_OFF_STATE:   spi_cmd = rpc_pkg::CMD_CRYSTAL_OFF_STATE;
			rpc_pkg::STB_SYNTH_ON_STATE: spi_cmd = rpc_pkg::CMD_SYNTH_ON_STATE;
			rpc_pkg::STB_CAL:    spi_cmd = rpc_pkg::CMD_CAL;
			default:             spi_cmd = rpc_pkg::CMD_NONE;
		endcase
	endfunction

	function automatic rpc_pkg::rpc_state_t cmd_target(input rpc_pkg::rpc_cmd_t c,
			input rpc_pkg::rpc_state_t cur);
		case (c)
			rpc_pkg::CMD_PWD:    cmd_target = rpc_pkg::ST_SLEEP;
			rpc_pkg::CMD_CRYSTAL_OFF_STATE:   cmd_target = rpc_pkg::ST_CRYSTAL_OFF_STATE;
			rpc_pkg::CMD_IDLE:   cmd_target = rpc_pkg::ST_IDLE;
			rpc_pkg::CMD_RX:     cmd_target = rpc_pkg::ST_RX;
			rpc_pkg::CMD_TX:     cmd_target = rpc_pkg::ST_TX;
			rpc_pkg::CMD_SYNTH_ON_STATE: cmd_target = rpc_pkg::ST_SYNTH_ON_STATE;
			rpc_pkg::CMD_CAL:    cmd_target = rpc_pkg::ST_MANUAL_CALIBRATION_STATE;
			default:             cmd_target = cur;
		endcase
	endfunction

	// link side: first header byte of a frame; cleared by the frame's own select
	assign link_rstn = rstn & ~chip_select_low;
	assign hdr = {lk.sh, spi_si};

	always_comb begin
		ln = lk;
		if (lk.first) begin
			ln.sh = hdr[6:0];
			ln.bitcnt = lk.bitcnt + 3'h1;
			if (lk.bitcnt == rpc_pkg::BYTE_LAST) begin
				ln.first = 1'b0;
				if (!hdr[6] && hdr[5:0] >= rpc_pkg::STROBE_FIRST
						&& hdr[5:0] <= rpc_pkg::STROBE_LAST) begin
					ln.hold = hdr[5:0];
					ln.valid = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge spi_sclk or negedge link_rstn) begin
		if (!link_rstn) begin
			lk <= '0;
			lk.first <= 1'b1;
		end else begin
			lk <= ln;
		end
	end

	always_comb begin
		n = r;
		n.s1 = {lk.valid, status_pin_a_in, spi_si, spi_sclk, chip_select_low};
		n.s2 = r.s1;
		n.prev = r.s2;
		cs_hi = r.s2[rpc_pkg::SY_CS];
		cs_fall = r.prev[rpc_pkg::SY_CS] & ~cs_hi;
		cmd = rpc_pkg::CMD_NONE;
		if (cfg.pin_control_enable && cs_fall) begin // see [RL6] [RL7]
			cmd = pin_cmd({r.prev[rpc_pkg::SY_SCLK], r.prev[rpc_pkg::SY_SI]});
		end else if (r.s2[rpc_pkg::SY_LV] && !r.prev[rpc_pkg::SY_LV]) begin // see [RL23]
			cmd = spi_cmd(lk.hold);
		end
		tgt = cmd_target(cmd, r.state);
		if (!cs_hi && (r.state == rpc_pkg::ST_SLEEP || r.state == rpc_pkg::ST_CRYSTAL_OFF_STATE)) begin
			n.state = rpc_pkg::ST_IDLE; // see [RL10]
		end
		if (r.state == rpc_pkg::ST_MANUAL_CALIBRATION_STATE) begin
			n.cal_cnt = r.cal_cnt - 4'h1;
			if (r.cal_cnt == 4'h0) begin
				n.state = rpc_pkg::ST_IDLE;
			end
		end
		if (r.pend != rpc_pkg::CMD_NONE && cs_hi) begin
			n.state = cmd_target(r.pend, r.state); // see [RL9]
			n.pend = rpc_pkg::CMD_NONE;
		end
		if (cmd == rpc_pkg::CMD_PWD || cmd == rpc_pkg::CMD_CRYSTAL_OFF_STATE) begin
			n.pend = cmd; // see [RL9]
		end else if (cmd == rpc_pkg::CMD_CAL) begin
			if (r.state == rpc_pkg::ST_IDLE) begin
				n.state = tgt;
				n.cal_cnt = rpc_pkg::CAL_CYCLES;
			end
		end else if (cmd != rpc_pkg::CMD_NONE && tgt != r.state) begin
			n.state = tgt; // see [RL8]
		end
		// pads
		if (!cs_hi) begin
			n.shared = '{out: spi_so_data, oe: 1'b1}; // see [RL1]
		end else if (cfg.sel_shared == rpc_pkg::SEL_TRISTATE) begin
			n.shared = '{out: 1'b0, oe: 1'b0}; // see [RL2]
		end else begin
			n.shared = '{out: status_vec[cfg.sel_shared], oe: 1'b1};
		end
		fs_on = r.state == rpc_pkg::ST_MANUAL_CALIBRATION_STATE || r.state == rpc_pkg::ST_SYNTH_ON_STATE
			|| r.state == rpc_pkg::ST_RX || r.state == rpc_pkg::ST_TX;
		n.temp_route = (cfg.production_test_reg == rpc_pkg::PRODUCTION_TEST_REG_DEFAULT && fs_on)
			|| (cfg.production_test_reg == rpc_pkg::PRODUCTION_TEST_REG_IDLE_TEMP
			&& r.state == rpc_pkg::ST_IDLE); // see [RL4]
		if ((cfg.serial_mode && r.state == rpc_pkg::ST_TX) || r.temp_route) begin
			n.pad_a = '{out: 1'b0, oe: 1'b0}; // see [RL3]
		end else begin
			n.pad_a = '{out: status_vec[cfg.sel_a], oe: 1'b1};
		end
		n.pad_b = '{out: status_vec[cfg.sel_b], oe: 1'b1};
		// symbol clock: phase accumulator nudged toward mid-symbol on data edges
		rate_sum = rpc_pkg::RATE_BASE + {1'b0, cfg.rate_mantissa};
		inc = rpc_pkg::rpc_acc_t'(rate_sum) << cfg.rate_exponent; // see [RL11] [RL13]
		nco = {1'b0, r.acc} + {1'b0, inc};
		nudge = {1'b0, inc >> rpc_pkg::NUDGE_SH};
		if (rx_data != r.rx_prev) begin // see [RL20]
			if (!r.acc[rpc_pkg::RATE_ACC_W-1]) begin
				nco = nco + nudge;
			end else begin
				nco = nco - nudge;
			end
		end
		n.acc = nco[rpc_pkg::RATE_ACC_W-1:0];
		n.sym_tick = nco[rpc_pkg::RATE_ACC_W];
		n.rx_prev = rx_data;
		if (nco[rpc_pkg::RATE_ACC_W]) begin
			n.rec_bit = rx_data;
		end
		// channel filter decimation
		bw_sum = rpc_pkg::BW_ADD + {1'b0, cfg.bandwidth_mantissa};
		bw_per = rpc_pkg::rpc_bwc_t'(bw_sum)
			<< (rpc_pkg::BW_FIX_SH + {1'b0, cfg.bandwidth_exponent}); // see [RL14]
		n.bw_tick = 1'b0;
		if (r.bw_cnt >= bw_per - rpc_pkg::rpc_bwc_t'(1)) begin
			n.bw_cnt = '0;
			n.bw_tick = 1'b1;
		end else begin
			n.bw_cnt = r.bw_cnt + rpc_pkg::rpc_bwc_t'(1);
		end
		// offset compensation
		ook = cfg.modem_config_two[rpc_pkg::MC2_MOD_HI:rpc_pkg::MC2_MOD_LO]
			== rpc_pkg::MOD_OOK;
		frozen = ook || (cfg.carrier_gate_bit && !carrier_sense)
			|| r.state != rpc_pkg::ST_RX; // see [RL17] [RL19]
		gain = r.post_sync ? cfg.postsync_gain : cfg.presync_gain; // see [RL18]
		step = freq_err >>> (rpc_pkg::GAIN_SH_MIN + {1'b0, gain});
		limit = (rpc_pkg::EST_SPAN >> cfg.bandwidth_exponent)
			>> (rpc_pkg::LIM_SH_MAX - {1'b0, cfg.offset_track_limit}); // see [RL16]
		lim_s = {2'b00, limit};
		acc_e = {r.est[7], r.est} + {step[7], step};
		if (acc_e > lim_s) begin
			acc_e = lim_s;
		end else if (acc_e < -lim_s) begin
			acc_e = -lim_s;
		end
		if (!frozen && r.sym_tick) begin
			n.est = acc_e[7:0]; // see [RL15]
		end
		if (synth_offset_write) begin
			n.tune = cfg.synth_offset_field; // see [RL15]
		end
		// sync word
		sync_on = cfg.modem_config_two[rpc_pkg::MC2_SYNC_HI:0] != rpc_pkg::SYNC_NONE;
		mode32 = cfg.modem_config_two[rpc_pkg::MC2_SYNC_HI:0] == rpc_pkg::SYNC_DUP_A
			|| cfg.modem_config_two[rpc_pkg::MC2_SYNC_HI:0] == rpc_pkg::SYNC_DUP_B;
		if (tx_packet_start && r.state == rpc_pkg::ST_TX && sync_on) begin
			n.tx_sh = {cfg.sync_word, cfg.sync_word}; // see [RL21]
			n.tx_left = mode32 ? rpc_pkg::SYNC_LEN32 : rpc_pkg::SYNC_LEN16;
		end else if (r.sym_tick && r.tx_left != 6'h0) begin
			n.tx_sh = {r.tx_sh[30:0], 1'b0};
			n.tx_left = r.tx_left - 6'h1;
		end
		if (r.tx_left != 6'h0) begin
			n.tx_bit = r.tx_sh[31];
		end else begin
			n.tx_bit = cfg.serial_mode & r.s2[rpc_pkg::SY_PA];
		end
		// clear first so that a sync hit in the same cycle wins
		if (packet_done || r.state != rpc_pkg::ST_RX) begin
			n.aligned = 1'b0;
			n.post_sync = 1'b0;
		end
		rx_new = {r.rx_sh[30:0], rx_data};
		hit = 1'b0;
		n.sync_hit = 1'b0;
		n.byte_valid = 1'b0;
		n.cs_prev = carrier_sense;
		if (r.state == rpc_pkg::ST_RX && nco[rpc_pkg::RATE_ACC_W]) begin
			n.rx_sh = rx_new;
			if (mode32) begin
				hit = rx_new == {cfg.sync_word, cfg.sync_word};
			end else begin
				hit = rx_new[15:0] == cfg.sync_word;
			end
			hit = hit && sync_on && !r.aligned; // see [RL21] [RL22]
			if (hit) begin
				n.aligned = 1'b1;
				n.sync_hit = 1'b1;
				n.post_sync = 1'b1;
				n.rx_bits = 3'h0;
			end else if (r.aligned) begin
				n.rx_bits = r.rx_bits + 3'h1;
				if (r.rx_bits == rpc_pkg::BYTE_LAST) begin
					n.byte_valid = 1'b1;
					n.rx_byte = rx_new[7:0];
				end
			end
		end
		if (!sync_on && carrier_sense && !r.cs_prev && r.state == rpc_pkg::ST_RX) begin
			n.aligned = 1'b1;
			n.rx_bits = 3'h0;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r <= '0;
			r.state <= rpc_pkg::ST_IDLE;
			// select idles high; a low reset value would fake a selected bus
			r.s1[rpc_pkg::SY_CS] <= 1'b1;
			r.s2[rpc_pkg::SY_CS] <= 1'b1;
			r.prev[rpc_pkg::SY_CS] <= 1'b1;
		end else begin
			r <= n;
		end
	end

	assign shared_status_out_pin = r.shared;
	assign status_pin_a          = r.pad_a;
	assign status_pin_b          = r.pad_b;
	assign radio_state           = r.state;
	assign temp_sensor_route     = r.temp_route;
	assign serial_tx_data        = r.s2[rpc_pkg::SY_PA];
	assign mod_tx_bit            = r.tx_bit;
	assign tx_sync_busy          = r.tx_left != 6'h0;
	assign symbol_tick           = r.sym_tick;
	assign recovered_bit         = r.rec_bit;
	assign bw_sample_tick        = r.bw_tick;
	assign offset_estimate       = r.est;
	assign synth_tune            = r.tune;
	assign sync_found            = r.sync_hit;
	assign rx_byte_valid         = r.byte_valid;
	assign rx_byte               = r.rx_byte;

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);

	AST_SO_SELECTED: assert property ( // see [RL1]
		!cs_hi |=> r.shared.oe && r.shared.out == $past(spi_so_data))
		else $error("shared pin not serial out while selected");
	AST_TRISTATE: assert property ( // see [RL2]
		cs_hi && cfg.sel_shared == rpc_pkg::SEL_TRISTATE |=> !r.shared.oe)
		else $error("shared pin driven in tristate option");
	AST_SERIAL_IN: assert property ( // see [RL3]
		cfg.serial_mode && r.state == rpc_pkg::ST_TX |=> !r.pad_a.oe)
		else $error("pin a driven during serial transmit");
	AST_TEMP_IDLE: assert property ( // see [RL4]
		cfg.production_test_reg == rpc_pkg::PRODUCTION_TEST_REG_DEFAULT && r.state == rpc_pkg::ST_IDLE
		|=> !r.temp_route)
		else $error("sensor routed in idle with default test value");
	AST_PIN_TX: assert property ( // see [RL7]
		cfg.pin_control_enable && cs_fall && !r.prev[rpc_pkg::SY_SCLK]
		&& r.prev[rpc_pkg::SY_SI] |=> r.state == rpc_pkg::ST_TX)
		else $error("pin strobe did not enter transmit");
	AST_PIN_OFF: assert property ( // see [RL6]
		!cfg.pin_control_enable && cs_fall && cmd == rpc_pkg::CMD_NONE
		&& r.pend == rpc_pkg::CMD_NONE && r.state == rpc_pkg::ST_RX
		|=> r.state == rpc_pkg::ST_RX)
		else $error("pins changed state with pin control off");
	AST_PWD_DEFER: assert property ( // see [RL9]
		r.pend == rpc_pkg::CMD_PWD && !cs_hi |=> r.state != rpc_pkg::ST_SLEEP)
		else $error("power-down ran while selected");
	AST_PWD_RUN: assert property ( // see [RL9]
		r.pend == rpc_pkg::CMD_PWD && cs_hi |=> r.state == rpc_pkg::ST_SLEEP)
		else $error("pending power-down not executed");
	AST_WAKE: assert property ( // see [RL10]
		!cs_hi && r.state == rpc_pkg::ST_SLEEP && cmd == rpc_pkg::CMD_NONE
		&& r.pend == rpc_pkg::CMD_NONE |=> r.state == rpc_pkg::ST_IDLE)
		else $error("select low did not wake to idle");
	AST_OOK_HOLD: assert property ( // see [RL19]
		ook |=> $stable(r.est))
		else $error("estimate moved under on-off keying");
	AST_GATE_HOLD: assert property ( // see [RL17]
		cfg.carrier_gate_bit && !carrier_sense |=> $stable(r.est))
		else $error("estimate moved before carrier sense");
	AST_BYTE_AFTER_SYNC: assert property ( // see [RL21]
		r.sync_hit |-> !r.byte_valid [*8])
		else $error("byte strobe too soon after sync");
	COV_PIN_RX: cover property (cfg.pin_control_enable && cmd == rpc_pkg::CMD_RX);
	COV_SPI_STROBE: cover property (r.s2[rpc_pkg::SY_LV] && !r.prev[rpc_pkg::SY_LV]);
	COV_SYNC: cover property (r.sync_hit ##[1:400] r.byte_valid);
	COV_WAKE: cover property (r.state == rpc_pkg::ST_SLEEP ##1 r.state == rpc_pkg::ST_IDLE);
endmodule
`default_nettype wire

// ===== test/rpc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module rpc_host_model (
	input  wire logic clk,             // crystal clock
	output var logic  spi_sclk,        // link clock
	output var logic  chip_select_low, // spi select
	output var logic  spi_si           // serial in
);
	initial begin
		spi_sclk = 1'b0;
		chip_select_low = 1'b1;
		spi_si = 1'b0;
	end
	// code pins settle well before select falls, select stays low afterwards
	task automatic pin_cmd(input logic [1:0] code);
		@(negedge clk);
		{spi_sclk, spi_si} = code;
		repeat (4) @(negedge clk);
		chip_select_low = 1'b0;
		repeat (8) @(negedge clk);
	endtask
	task automatic release_cs();
		@(negedge clk);
		chip_select_low = 1'b1;
		repeat (8) @(negedge clk);
	endtask
	// one header byte msb first; link clock runs only inside the frame
	task automatic spi_byte(input logic [7:0] b);
		integer i;
		@(negedge clk);
		spi_sclk = 1'b0;
		chip_select_low = 1'b0;
		#17;
		for (i = 7; i >= 0; i--) begin
			spi_si = b[i];
			#6 spi_sclk = 1'b1;
			#6 spi_sclk = 1'b0;
		end
		spi_si = ~spi_si;
		#60 chip_select_low = 1'b1;
	endtask
endmodule
`default_nettype wire

// ===== test/test_rpc_radio_pin_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_rpc_radio_pin_ctrl;
	logic               clk;
	logic               rstn;
	logic               spi_sclk;
	logic               chip_select_low;
	logic               spi_si;
	logic               spi_so_data;
	rpc_pkg::rpc_cfg_t  cfg;
	rpc_pkg::rpc_pad_t  shared_pad;
	rpc_pkg::rpc_pad_t  pad_a;
	rpc_pkg::rpc_state_t st;
	logic               temp_route;
	logic               bw_tick;
	logic               sym_tick;
	logic               pin_a_in;
	logic               ser_tx;
	logic               tx_bit;
	logic               offset_wr;
	logic [7:0]         tune;
	logic [63:0]        status_vec;
	int                 fails;
	int                 checked;
	int                 cyc;

	rpc_host_model u_rpc_host_model (.clk(clk), .spi_sclk(spi_sclk),
		.chip_select_low(chip_select_low), .spi_si(spi_si));

	rpc_radio_pin_ctrl u_rpc_radio_pin_ctrl (.clk(clk), .rstn(rstn), .spi_sclk(spi_sclk),
		.chip_select_low(chip_select_low), .spi_si(spi_si), .spi_so_data(spi_so_data),
		.status_pin_a_in(pin_a_in), .cfg(cfg), .status_vec(status_vec), .rx_data(1'b0),
		.freq_err(8'sh0), .carrier_sense(1'b0), .tx_packet_start(1'b0),
		.packet_done(1'b0), .synth_offset_write(offset_wr),
		.shared_status_out_pin(shared_pad), .status_pin_a(pad_a), .status_pin_b(),
		.radio_state(st), .temp_sensor_route(temp_route), .serial_tx_data(ser_tx),
		.mod_tx_bit(tx_bit), .tx_sync_busy(), .symbol_tick(sym_tick), .recovered_bit(),
		.bw_sample_tick(bw_tick), .offset_estimate(), .synth_tune(tune), .sync_found(),
		.rx_byte_valid(), .rx_byte());

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			fails++;
			finish_test();
		end
	end

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_state(input rpc_pkg::rpc_state_t exp);
		chk("radio state", {5'h0, exp}, {5'h0, st});
	endtask

	task automatic t_reset();
		chk("shared oe", 8'h0, {7'h0, shared_pad.oe});
		chk_state(rpc_pkg::ST_IDLE);
		$display("test reset done");
	endtask

	task automatic t_pins();
		cfg.pin_control_enable = 1'b1;
		u_rpc_host_model.pin_cmd(rpc_pkg::PIN_TX);
		chk_state(rpc_pkg::ST_TX);
		chk("sensor route tx", 8'h1, {7'h0, temp_route});
		spi_so_data = 1'b1;
		repeat (3) @(negedge clk);
		chk("shared drive", 8'h3, {6'h0, shared_pad});
		spi_so_data = 1'b0;
		repeat (3) @(negedge clk);
		chk("shared drive", 8'h1, {6'h0, shared_pad});
		u_rpc_host_model.release_cs();
		u_rpc_host_model.pin_cmd(rpc_pkg::PIN_TX);
		chk_state(rpc_pkg::ST_TX);
		u_rpc_host_model.release_cs();
		u_rpc_host_model.pin_cmd(rpc_pkg::PIN_RX);
		chk_state(rpc_pkg::ST_RX);
		u_rpc_host_model.release_cs();
		cfg.pin_control_enable = 1'b0;
		u_rpc_host_model.pin_cmd(rpc_pkg::PIN_TX);
		chk_state(rpc_pkg::ST_RX);
		u_rpc_host_model.release_cs();
		cfg.pin_control_enable = 1'b1;
		u_rpc_host_model.pin_cmd(rpc_pkg::PIN_IDLE);
		chk_state(rpc_pkg::ST_IDLE);
		chk("sensor route idle", 8'h0, {7'h0, temp_route});
		cfg.production_test_reg = rpc_pkg::PRODUCTION_TEST_REG_IDLE_TEMP;
		repeat (3) @(negedge clk);
		chk("sensor route alt", 8'h1, {7'h0, temp_route});
		cfg.production_test_reg = rpc_pkg::PRODUCTION_TEST_REG_DEFAULT;
		u_rpc_host_model.release_cs();
		chk("shared oe high", 8'h0, {7'h0, shared_pad.oe});
		u_rpc_host_model.pin_cmd(rpc_pkg::PIN_PWD);
		chk_state(rpc_pkg::ST_IDLE);
		u_rpc_host_model.release_cs();
		chk_state(rpc_pkg::ST_SLEEP);
		cfg.pin_control_enable = 1'b0;
		u_rpc_host_model.pin_cmd(rpc_pkg::PIN_TX);
		chk_state(rpc_pkg::ST_IDLE);
		u_rpc_host_model.release_cs();
		$display("test pin control done");
	endtask

	task automatic tick_gap(input logic sym, output int n);
		repeat (2) begin
			n = 0;
			do begin
				@(negedge clk);
				n++;
			end while ((sym ? sym_tick : bw_tick) !== 1'b1 && n < 300);
		end
	endtask

	task automatic t_bw();
		int n;
		int exp;
		cfg.bandwidth_mantissa = 2'h1;
		cfg.bandwidth_exponent = 2'h1;
		exp = 8 * (4 + 1) * 2;
		tick_gap(1'b0, n);
		chk("filter period", exp[7:0], n[7:0]);
		$display("test filter done");
	endtask

	task automatic t_rate();
		int n;
		int exp;
		cfg.rate_mantissa = 8'h0;
		cfg.rate_exponent = 4'he; // mantissa 256 at exponent 14, carried
		exp = (1 << 28) / (256 << 14);
		tick_gap(1'b1, n);
		chk("symbol period", exp[7:0], n[7:0]);
		cfg.rate_exponent = 4'hf;
		exp = (1 << 28) / (256 << 15);
		tick_gap(1'b1, n);
		chk("symbol period step", exp[7:0], n[7:0]);
		$display("test data rate done");
	endtask

	task automatic t_spi();
		u_rpc_host_model.spi_byte({2'h0, rpc_pkg::STB_TX});
		repeat (8) @(negedge clk);
		chk_state(rpc_pkg::ST_TX);
		$display("test spi strobe done");
	endtask

	task automatic t_pads();
		status_vec = 64'h20;
		cfg.sel_shared = 6'h05;
		repeat (3) @(negedge clk);
		chk("shared status", 8'h3, {6'h0, shared_pad});
		cfg.sel_shared = rpc_pkg::SEL_TRISTATE;
		pin_a_in = 1'b1;
		repeat (4) @(negedge clk);
		chk("serial tx in", 8'h1, {7'h0, ser_tx});
		chk("modulator bit", 8'h1, {7'h0, tx_bit});
		chk("pin a oe", 8'h0, {7'h0, pad_a.oe});
		pin_a_in = 1'b0;
		repeat (4) @(negedge clk);
		chk("serial tx in", 8'h0, {7'h0, ser_tx});
		cfg.synth_offset_field = 8'h5a;
		offset_wr = 1'b1;
		@(negedge clk);
		offset_wr = 1'b0;
		cfg.synth_offset_field = 8'ha5;
		repeat (2) @(negedge clk);
		chk("synth tune", 8'h5a, tune);
		$display("test pads done");
	endtask

	initial begin
		fails = 0;
		checked = 0;
		cyc = 0;
		rstn = 1'b0;
		spi_so_data = 1'b0;
		cfg = '0;
		cfg.production_test_reg = rpc_pkg::PRODUCTION_TEST_REG_DEFAULT;
		cfg.sel_shared = rpc_pkg::SEL_TRISTATE;
		cfg.sel_a = rpc_pkg::SEL_TRISTATE;
		cfg.sel_b = rpc_pkg::SEL_TRISTATE;
		cfg.serial_mode = 1'b1;
		status_vec = 64'h0;
		pin_a_in = 1'b0;
		offset_wr = 1'b0;
		repeat (8) @(negedge clk);
		rstn = 1'b1;
		repeat (2) @(negedge clk);
		t_reset();
		t_pins();
		t_bw();
		t_rate();
		t_spi();
		t_pads();
		finish_test();
	end
endmodule
`default_nettype wire
